// ==== design/mtpo_pkg.sv ====
package mtpo_pkg;

   // Block shape
   localparam int NUM_UNITS = 5;
   localparam int NUM_CMP   = 12;
   localparam int NUM_TOUT  = 10;
   localparam int NUM_IRQ   = 15;
   localparam int CNT_W     = 16;
   localparam int PORT0_W   = 4;
   localparam int PATTERN_W = 8;

   // Register offsets in the low segment
   localparam logic [15:0] ADDR_PATTERN_BUF = 16'hff0e;
   localparam logic [15:0] TM_ADDR [NUM_UNITS] = '{
      16'hff10, 16'hff1a, 16'hff50, 16'hff56, 16'hff60};
   // Compare registers; index 10 and 11 are timer4_compare_a and _b
   localparam logic [15:0] CMP_ADDR [NUM_CMP] = '{
      16'hff12, 16'hff14, 16'hff16, 16'hff18,
      16'hff1c, 16'hff1e, 16'hff52, 16'hff54,
      16'hff58, 16'hff5a, 16'hff62, 16'hff64};
   localparam int IDX_TIMER4_COMPARE_A = 10;

   // Added to every offset when the high segment is selected
   localparam logic [19:0] RELOC_OFFSET = 20'hf0000;

   // Owning unit of each compare channel
   localparam int CMP_UNIT [NUM_CMP] = '{0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4};

   // Prescaler: log2 of the slowest-but-four divisor per unit
   localparam int PRESC_BASE [NUM_UNITS] = '{2, 3, 2, 2, 2};
   localparam logic [2:0] PRESC_SEL_MAX = 3'h4;
   localparam int PRESC_W = 7;

   // Values after reset
   localparam logic [15:0] CNT_RESET     = 16'h0000;
   localparam logic [15:0] CMP_RESET     = 16'h0000;
   localparam logic [7:0]  PATTERN_RESET = 8'h00;
   localparam logic [3:0]  PORT0_RESET   = 4'h0;

   // Timer output modes
   typedef enum logic [1:0] {
      MTPO_OUT_TOGGLE,
      MTPO_OUT_SETRESET,
      MTPO_OUT_PWM,
      MTPO_OUT_PPG
   } mtpo_out_mode_e;

   // One special-function-register access
   typedef struct packed {
      logic [19:0] addr;
      logic        wr;
      logic        rd;
      logic        word;
      logic [15:0] wdata;
   } mtpo_sfr_req_s;

endpackage

// ==== design/mtpo_top.sv ====
// Behaviour
// - Five 16-bit counters: plain timers 0, 1, 4; timer/counters 2, 3.
// - Interrupt requests: five, three, two, two, three per unit; fifteen total.
// - Unit 0 has four compare channels, units 1 to 4 two each.
// - Only units 2 and 3 may count external events from a pin.
// - Output pins: four on unit 0, two on 1-3, none on 4; toggle.
// - Set/reset output operation exists on units 0 and 1 only.
// - PWM and programmable pulse outputs exist on units 2 and 3 only.
// - Overflow interrupt on units 0, 1, 4; none on units 2, 3.
// - Each unit 4 match copies the pattern buffer onto the port pins.
// - Port 0 pins driven from the pattern_buffer_register, preloaded by software.
// - Units 0, 2, 3, 4 count at clock divided by 4 to 64.
// - Unit 1 counts at clock divided by 8 to 128.
// - timer4_compare_a is reached by 16-bit word access only.
// - High segment selection moves every register address up by F0000H.
// - Each unit 4 compare register raises its own match interrupt.
`timescale 1ns/1ps
`default_nettype none

module mtpo_top (
   // Clock and reset
   input  wire logic                      mclk,
   input  wire logic                      nrst,
   // Register access
   input  wire mtpo_pkg::mtpo_sfr_req_s   sfr_req,
   input  wire logic                      reloc_high,
   output logic [15:0]                    sfr_rdata,
   // Unit configuration
   input  wire logic [4:0]                count_run,
   input  wire logic [4:0][2:0]           prescale_sel,
   input  wire logic [1:0]                event_count,
   input  wire logic [3:0][1:0]           out_mode,
   // External event pins of units 2 and 3
   input  wire logic [1:0]                event_pin,
   // Timer pins, interrupt requests and pattern port
   output logic [9:0]                     timer_out,
   output logic [14:0]                    irq_req,
   output logic [3:0]                     port0_out
);

   // Counter state and compare storage
   logic [15:0] cnt [mtpo_pkg::NUM_UNITS];
   logic [15:0] cmp [mtpo_pkg::NUM_CMP];
   logic [7:0]  pattern_buffer_register;
   logic [6:0]  presc;

   // Per-cycle events
   logic [4:0]  step;
   logic [4:0]  ovf;
   logic [11:0] match;
   logic [1:0]  ev_meta;
   logic [1:0]  ev_sync;
   logic [1:0]  ev_last;
   logic [1:0]  ev_edge;
   logic [15:0] next_rdata;

   // Full address of an offset in the current segment
   function automatic logic [19:0] full_addr(input logic [15:0] off,
                                             input logic        high);
      logic [19:0] base;
      base = {4'h0, off};
      return high ? base + mtpo_pkg::RELOC_OFFSET : base;
   endfunction

   // Prescaler tap: true once every 2**n clocks
   function automatic logic presc_tick(input logic [6:0] free,
                                       input int         base,
                                       input logic [2:0] sel);
      logic [2:0] s;
      logic [6:0] mask;
      s    = (sel > mtpo_pkg::PRESC_SEL_MAX) ? mtpo_pkg::PRESC_SEL_MAX : sel;
      mask = 7'((1 << (base + int'(s))) - 1);
      return (free & mask) == mask;
   endfunction

   // Free-running prescaler shared by all units
   // divider chain
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         presc <= '0;
      end else begin
         presc <= presc + 7'h01;
      end
   end

   // Event pins: two flops, then a third for edge detection
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ev_meta <= '0;
         ev_sync <= '0;
         ev_last <= '0;
      end else begin
         ev_meta <= event_pin;
         ev_sync <= ev_meta;
         ev_last <= ev_sync;
      end
   end

   assign ev_edge = ev_sync & ~ev_last;

   // Count source per unit; event mode ignored on units without a pin
   always_comb begin
      for (int u = 0; u < mtpo_pkg::NUM_UNITS; u++) begin
         step[u] = count_run[u] &&
                   presc_tick(presc, mtpo_pkg::PRESC_BASE[u],
                              prescale_sel[u]);
      end
      for (int e = 0; e < 2; e++) begin
         if (event_count[e]) begin
            step[e + 2] = count_run[e + 2] && ev_edge[e];
         end
      end
   end

   // Counters
   // five counters
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         for (int u = 0; u < mtpo_pkg::NUM_UNITS; u++) begin
            cnt[u] <= mtpo_pkg::CNT_RESET;
         end
      end else begin
         for (int u = 0; u < mtpo_pkg::NUM_UNITS; u++) begin
            if (step[u]) begin
               cnt[u] <= cnt[u] + 16'h0001;
            end
         end
      end
   end

   // Overflow pulse in the cycle the counter has just wrapped to zero
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ovf <= '0;
      end else begin
         for (int u = 0; u < mtpo_pkg::NUM_UNITS; u++) begin
            ovf[u] <= step[u] && (cnt[u] == 16'hffff);
         end
      end
   end

   // Match pulse in the cycle the counter has just reached the compare;
   // testing on the step keeps a held count from firing again
   // compare channels
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         match <= '0;
      end else begin
         for (int k = 0; k < mtpo_pkg::NUM_CMP; k++) begin
            match[k] <= step[mtpo_pkg::CMP_UNIT[k]] &&
                        (cnt[mtpo_pkg::CMP_UNIT[k]] + 16'h0001 == cmp[k]);
         end
      end
   end

   // Interrupt requests in unit order
   // fifteen requests
   assign irq_req = {match[11], match[10], ovf[4],
                     match[9], match[8],
                     match[7], match[6],
                     match[5], match[4], ovf[1],
                     match[3:0], ovf[0]};

   // Timer pins; output k follows compare channel k
   // toggle outputs
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         timer_out <= '0;
      end else begin
         for (int k = 0; k < mtpo_pkg::NUM_TOUT; k++) begin
            case (mtpo_pkg::mtpo_out_mode_e'(out_mode[mtpo_pkg::CMP_UNIT[k]]))
               mtpo_pkg::MTPO_OUT_SETRESET: begin
                  if (mtpo_pkg::CMP_UNIT[k] < 2) begin
                     if (match[k]) begin
                        timer_out[k] <= 1'b1;
                     end else if (match[k ^ 1]) begin
                        timer_out[k] <= 1'b0;
                     end
                  end else if (match[k]) begin
                     timer_out[k] <= ~timer_out[k];
                  end
               end
               mtpo_pkg::MTPO_OUT_PWM: begin
                  if (mtpo_pkg::CMP_UNIT[k] >= 2) begin
                     if (ovf[mtpo_pkg::CMP_UNIT[k]]) begin
                        timer_out[k] <= 1'b1;
                     end else if (match[k]) begin
                        timer_out[k] <= 1'b0;
                     end
                  end else if (match[k]) begin
                     timer_out[k] <= ~timer_out[k];
                  end
               end
               mtpo_pkg::MTPO_OUT_PPG: begin
                  if (mtpo_pkg::CMP_UNIT[k] >= 2) begin
                     if (match[k & ~1]) begin
                        timer_out[k] <= 1'b1;
                     end else if (match[k | 1]) begin
                        timer_out[k] <= 1'b0;
                     end
                  end else if (match[k]) begin
                     timer_out[k] <= ~timer_out[k];
                  end
               end
               default: begin
                  if (match[k]) begin
                     timer_out[k] <= ~timer_out[k];
                  end
               end
            endcase
         end
      end
   end

   // Pattern port; copying on the match avoids software timing jitter
   // copy on unit 4 match
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         port0_out <= mtpo_pkg::PORT0_RESET;
      end else if (match[mtpo_pkg::IDX_TIMER4_COMPARE_A] ||
                   match[mtpo_pkg::IDX_TIMER4_COMPARE_A + 1]) begin
         port0_out <= pattern_buffer_register[3:0];
      end
   end

   // Pattern buffer: byte register, low lane of the write data
   // relocated decode
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pattern_buffer_register <= mtpo_pkg::PATTERN_RESET;
      end else if (sfr_req.wr && !sfr_req.word &&
                   sfr_req.addr == full_addr(mtpo_pkg::ADDR_PATTERN_BUF,
                                             reloc_high)) begin
         pattern_buffer_register <= sfr_req.wdata[7:0];
      end
   end

   // Compare registers take word writes only; byte writes are dropped
   // word access only
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         for (int k = 0; k < mtpo_pkg::NUM_CMP; k++) begin
            cmp[k] <= mtpo_pkg::CMP_RESET;
         end
      end else begin
         for (int k = 0; k < mtpo_pkg::NUM_CMP; k++) begin
            if (sfr_req.wr && sfr_req.word &&
                sfr_req.addr == full_addr(mtpo_pkg::CMP_ADDR[k],
                                          reloc_high)) begin
               cmp[k] <= sfr_req.wdata;
            end
         end
      end
   end

   // Read decode; unmapped or wrong-width reads return zero
   // word read only, byte read for the pattern buffer
   always_comb begin
      next_rdata = 16'h0000;
      if (sfr_req.addr == full_addr(mtpo_pkg::ADDR_PATTERN_BUF,
                                    reloc_high)) begin
         if (!sfr_req.word) begin
            next_rdata = {8'h00, pattern_buffer_register};
         end
      end else begin
         for (int u = 0; u < mtpo_pkg::NUM_UNITS; u++) begin
            if (sfr_req.word &&
                sfr_req.addr == full_addr(mtpo_pkg::TM_ADDR[u],
                                          reloc_high)) begin
               next_rdata = cnt[u];
            end
         end
         for (int k = 0; k < mtpo_pkg::NUM_CMP; k++) begin
            if (sfr_req.word &&
                sfr_req.addr == full_addr(mtpo_pkg::CMP_ADDR[k],
                                          reloc_high)) begin
               next_rdata = cmp[k];
            end
         end
      end
   end

   // Read data register, held until the next read
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sfr_rdata <= 16'h0000;
      end else if (sfr_req.rd) begin
         sfr_rdata <= next_rdata;
      end
   end

endmodule

`default_nettype wire

// ==== tb/mtpo_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module mtpo_chk (
   // Clock and reset
   input wire logic            mclk,
   input wire logic            nrst,
   // Watched ports
   input wire logic [4:0][2:0] prescale_sel,
   input wire logic [3:0][1:0] out_mode,
   input wire logic [9:0]      timer_out,
   input wire logic [14:0]     irq_req,
   input wire logic [3:0]      port0_out
);
   logic [6:0] p;
   // Shadow prescaler; an irq outside its tick window shows a wrong rate
   always_ff @(posedge mclk) begin
      p <= nrst ? p + 7'h01 : 7'h00;
   end
   // Mask of the low prescaler bits that define one tick
   function automatic logic [6:0] msk(input logic [2:0] s, input int b);
      return (7'h01 << (s + b)) - 7'h01;
   endfunction
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!nrst);
   irq_pulse_a: assert property ((irq_req != 15'h0) |=>
      ((irq_req & $past(irq_req)) == 15'h0)) else $error("irq too long");
   pattern_load_a: assert property ((port0_out != $past(port0_out)) |->
      ((irq_req[14:13] | $past(irq_req[14:13])) != 2'h0))
      else $error("port changed without match");
   out_cause_a: assert property ((timer_out[3:0] != $past(timer_out[3:0]))
      |-> ((irq_req[4:1] | $past(irq_req[4:1])) != 4'h0))
      else $error("unit0 output moved alone");
   toggle_out_a: assert property ((out_mode[0] == 2'h0 && irq_req[1])
      |-> ##[0:1] (timer_out[0] != $past(timer_out[0])))
      else $error("no toggle on match");
   set_out_a: assert property ((out_mode[1] == 2'h1 && irq_req[6])
      |-> ##[0:1] timer_out[4]) else $error("set output missed");
   ppg_out_a: assert property ((out_mode[2] == 2'h3 && irq_req[8])
      |-> ##[0:1] (timer_out[7:6] == 2'h3)) else $error("pulse not set");
   u0_tick_a: assert property ((irq_req[4:0] != 5'h0) |->
      ((p & msk(prescale_sel[0], 2)) <= 7'h01)) else $error("unit0 rate");
   u1_tick_a: assert property ((irq_req[7:5] != 3'h0) |->
      ((p & msk(prescale_sel[1], 3)) <= 7'h01)) else $error("unit1 rate");
   u4_tick_a: assert property ((irq_req[14:12] != 3'h0) |->
      ((p & msk(prescale_sel[4], 2)) <= 7'h01)) else $error("unit4 rate");
endmodule
bind mtpo_top mtpo_chk chk_u (.mclk(mclk), .nrst(nrst),
   .prescale_sel(prescale_sel), .out_mode(out_mode),
   .timer_out(timer_out), .irq_req(irq_req), .port0_out(port0_out));
`default_nettype wire

// ==== tb/mtpo_event_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module mtpo_event_src (
   // Clock and pacing
   input  wire logic       mclk,
   input  wire logic       run,
   input  wire logic [3:0] half,
   // Event pins of units 2 and 3
   output logic [1:0]      event_pin
);
   logic [3:0] cnt;
   // Square wave of 2*(half+1) cycles; pins rest low when idle, no stray edge
   always_ff @(posedge mclk) begin
      cnt <= (!run || cnt >= half) ? 4'h0 : cnt + 4'h1;
      if (!run) begin
         event_pin <= 2'h0;
      end else if (cnt >= half) begin
         event_pin <= ~event_pin;
      end
   end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                    mclk;
   logic                    nrst;
   mtpo_pkg::mtpo_sfr_req_s sfr_req;
   logic                    reloc_high;
   logic [15:0]             sfr_rdata;
   logic [4:0]              count_run;
   logic [4:0][2:0]         prescale_sel;
   logic [1:0]              event_count;
   logic [3:0][1:0]         out_mode;
   logic [1:0]              event_pin;
   logic [9:0]              timer_out;
   logic [14:0]             irq_req;
   logic [3:0]              port0_out;
   logic                    ev_run;
   logic [3:0]              ev_half;
   logic                    rd_q;
   logic                    ev_prev;
   logic [3:0]              seg;
   logic [6:0]              p;
   logic [6:0]              m [5];
   logic [15:0]             tk [5];
   logic [15:0]             ic [15];
   logic [15:0]             ev_n;
   logic [15:0]             cv;
   logic [7:0]              bv;
   logic [15:0]             exp_q [$];
   int                      seed = 32'heee6;
   int                      err_total = 0;
   int                      n_checks = 0;
   localparam logic [15:0]  CA = mtpo_pkg::CMP_ADDR[10];
   localparam logic [15:0]  PB = mtpo_pkg::ADDR_PATTERN_BUF;
   localparam logic [15:0]  FV [12] = '{16'h1, 16'h2, 16'h3, 16'h4,
      16'h2, 16'h5, 16'h6, 16'h3, 16'h1, 16'h2, 16'h3, 16'h5};
   mtpo_top dut_u (.mclk(mclk), .nrst(nrst), .sfr_req(sfr_req),
      .reloc_high(reloc_high), .sfr_rdata(sfr_rdata),
      .count_run(count_run), .prescale_sel(prescale_sel),
      .event_count(event_count), .out_mode(out_mode),
      .event_pin(event_pin), .timer_out(timer_out),
      .irq_req(irq_req), .port0_out(port0_out));
   mtpo_event_src ev_u (.mclk(mclk), .run(ev_run), .half(ev_half),
      .event_pin(event_pin));
   // 40 MHz clock
   always #12.5 mclk = ~mclk;
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One register cycle; a read notes the answer it should get
   task automatic acc(input logic [15:0] a, input logic w,
                      input logic wd, input logic [15:0] d);
      @(posedge mclk);
      #1;
      if (!w) exp_q.push_back(d);
      sfr_req = '{{seg, a}, w, !w, wd, d};
      @(posedge mclk);
      #1;
      sfr_req = '0;
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Read answers land one edge after the request; check at mid-cycle
   always @(negedge mclk) begin
      if (rd_q) chk(sfr_rdata, exp_q.pop_front());
   end
   // Reference tallies: ticks per unit, unit3 pin rises, irq pulses
   always @(posedge mclk) begin
      rd_q <= nrst && sfr_req.rd;
      ev_prev <= event_pin[1];
      p <= nrst ? p + 7'h1 : 7'h0;
      ev_n <= !nrst ? 16'h0 : ev_n + 16'(event_pin[1] && !ev_prev);
      for (int u = 0; u < 5; u++) begin
         if (!nrst) tk[u] <= 16'h0;
         else if (count_run[u] && (p & m[u]) == m[u]) tk[u] <= tk[u] + 16'h1;
      end
      for (int k = 0; k < 15; k++) begin
         if (!nrst) ic[k] <= 16'h0;
         else if (irq_req[k]) ic[k] <= ic[k] + 16'h1;
      end
   end
   // Watchdog; the sequence needs about 1700 cycles
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      end_of_test();
   end
   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      sfr_req = '0;
      seg = 4'h0;
      reloc_high = 1'b0;
      count_run = 5'h00;
      // Unit3 counts pin events; u2 PROGRAMMABLE_PULSE_OUTPUT, u1 set/reset, u0 and u3 toggle
      event_count = 2'h2;
      out_mode = 8'h34;
      ev_run = 1'b0;
      ev_half = 4'h1;
      for (int u = 0; u < 5; u++) begin
         prescale_sel[u] = 3'($unsigned($random(seed)) % 5);
         m[u] = (7'h1 << (prescale_sel[u] + (u == 1 ? 3 : 2))) - 7'h1;
      end
      repeat (5) @(posedge mclk);
      #1 nrst = 1'b1;
      for (int k = 0; k < 5; k++) acc(mtpo_pkg::TM_ADDR[k], 0, 1, 16'h0);
      for (int k = 0; k < 12; k++) begin
         cv = 16'($random(seed));
         acc(mtpo_pkg::CMP_ADDR[(k + 11) % 12], 1, 1, cv);
         acc(mtpo_pkg::CMP_ADDR[(k + 11) % 12], 0, 1, cv);
      end
      acc(CA, 1, 0, ~cv);
      acc(CA, 0, 1, cv);
      acc(CA, 0, 0, 16'h0);
      acc(mtpo_pkg::TM_ADDR[4], 1, 1, 16'h1234);
      acc(mtpo_pkg::TM_ADDR[4], 0, 1, 16'h0);
      acc(16'hff66, 0, 1, 16'h0);
      reloc_high = 1'b1;
      seg = mtpo_pkg::RELOC_OFFSET[19:16];
      acc(CA, 1, 1, 16'h5a5a);
      acc(CA, 0, 1, 16'h5a5a);
      seg = 4'h0;
      acc(CA, 0, 1, 16'h0);
      reloc_high = 1'b0;
      acc(CA, 0, 1, 16'h5a5a);
      for (int k = 0; k < 12; k++) acc(mtpo_pkg::CMP_ADDR[k], 1, 1, FV[k]);
      bv = 8'($random(seed)) | 8'h01;
      acc(PB, 1, 0, {8'h0, bv});
      // Word access to the byte-wide buffer is refused both ways
      acc(PB, 1, 1, {8'h0, ~bv});
      acc(PB, 0, 1, 16'h0);
      acc(PB, 0, 0, {8'h0, bv});
      count_run = 5'h1f;
      ev_run = 1'b1;
      repeat (700) @(posedge mclk);
      #1 ev_half = 4'h9;
      repeat (800) @(posedge mclk);
      #1 ev_run = 1'b0;
      repeat (6) @(posedge mclk);
      #1 count_run = 5'h00;
      for (int u = 0; u < 5; u++) begin
         acc(mtpo_pkg::TM_ADDR[u], 0, 1, u == 3 ? ev_n : tk[u]);
      end
      for (int k = 0; k < 15; k++) begin
         chk(ic[k], 16'(k != 0 && k != 5 && k != 12));
      end
      chk({6'h0, timer_out}, 16'h03ef);
      chk({12'h0, port0_out}, {12'h0, bv[3:0]});
      acc(PB, 1, 0, {8'h0, ~bv});
      repeat (4) @(posedge mclk);
      #1 chk({12'h0, port0_out}, {12'h0, bv[3:0]});
      // Second run: unit 3 in PWM is cleared by its own matches, unit 2
      // now counts pin events; compares sit just ahead of the held count
      cv = tk[2] - ev_n;
      out_mode = 8'hb4;
      event_count = 2'h3;
      acc(mtpo_pkg::CMP_ADDR[8], 1, 1, ev_n + 16'h2);
      acc(mtpo_pkg::CMP_ADDR[9], 1, 1, ev_n + 16'h4);
      ev_half = 4'h1;
      count_run = 5'h0c;
      ev_run = 1'b1;
      repeat (60) @(posedge mclk);
      #1 ev_run = 1'b0;
      repeat (6) @(posedge mclk);
      #1 count_run = 5'h00;
      acc(mtpo_pkg::TM_ADDR[2], 0, 1, cv + ev_n);
      acc(mtpo_pkg::TM_ADDR[3], 0, 1, ev_n);
      chk({6'h0, timer_out}, 16'h00ef);
      chk(ic[10], 16'h2);
      chk(ic[11], 16'h2);
      end_of_test();
   end
endmodule
`default_nettype wire
